/* File: wcol_top.sv */
// Ratio/range decode and operator current offset limiter with APB registers
//
// Functional notes
// - In ratio modes the ratio is the whole part of ratio/range, at most 125.
// - In percent mode the range is the fraction part, 00.00 to 00.99.
// - In kA mode ratio/range is the maximum RMS secondary current as xx.xx kA.
// - Offset code 00 and 20 disable, 01-19 single schedule, 21-39 all schedules.
// - Offset magnitude is the code in percent, or the code minus twenty for all.
// - The data display prefix is S for codes 1-19 and A for codes 21-39.
// - In operate mode only the weld current moves, within base plus or minus offset.
// - An adjustment past a window edge stores and shows that edge value.
// - In kA constant current mode enter commits; otherwise each press stores at once.
// - Single mode changes only the shown schedule; all mode shifts every schedule.
// - Program mode alternates base and offset display while an offset is active; enter copies offset to base.
// - Program mode flashes the current display while an offset is active.
// - Constant current code 00 disables; tens give sensor, units give monitor only.
`timescale 1ns/1ps
module wcol_top import wcol_pkg::*; #(
   parameter int NSCHED = 8,
   parameter int ALT_CYC = ALT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic btn_up_pin,
   input wire logic btn_down_pin,
   input wire logic btn_enter_pin,
   output logic [CW-1:0] disp_value,
   output logic [1:0] disp_prefix,
   output logic disp_flash,
   output logic disp_offset_shown
);
   localparam int SW = (NSCHED > 1) ? $clog2(NSCHED) : 1;
   localparam int TW = $clog2(ALT_CYC + 1);

   typedef struct packed {
      logic prog;
      logic range_ka;
      logic [6:0] cc_code;
      logic [5:0] off_code;
      logic [6:0] rr_int;
      logic [6:0] rr_frac;
      logic [SW-1:0] sel;
      logic [NSCHED-1:0][CW-1:0] base;
      logic [NSCHED-1:0][CW:0] dlt;
      logic [CW-1:0] edit;
      logic pend;
      logic alt;
      logic [TW-1:0] tcnt;
      logic [CW-1:0] disp;
      logic [1:0] pfx;
      logic flash;
      logic shown;
      logic [31:0] prdata;
      logic pslverr;
   } wcol_st_t;

   wcol_st_t st_reg, st_next;
   wcol_btn_t bt;
   logic [2:0] press;

   // Clamped offset current of one schedule
   function automatic logic [CW-1:0] wk(input logic [CW-1:0] b, input logic [CW:0] d);
      logic [CW+1:0] s;
      s = {2'b00, b} + {d[CW], d};
      if (s[CW+1]) begin
         wk = '0;
      end else if (s[CW:0] > {1'b0, CUR_MAX}) begin
         wk = CUR_MAX;
      end else begin
         wk = s[CW-1:0];
      end
   endfunction

   // Button pins cross into the clock domain here
   wcol_btn_sync #(.N(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({btn_up_pin, btn_down_pin, btn_enter_pin}),
      .press(press)
   );
   assign bt = wcol_btn_t'(press);

   // Per-schedule offset current and equal-shift check
   logic [NSCHED-1:0][CW-1:0] wk_all;
   logic [NSCHED-1:0] dlt_eq;
   genvar gi;
   generate
      for (gi = 0; gi < NSCHED; gi++) begin : g_sch
         assign wk_all[gi] = wk(st_reg.base[gi], st_reg.dlt[gi]);
         assign dlt_eq[gi] = (st_reg.dlt[gi] == st_reg.dlt[0]);
      end
   endgenerate

   // Constant current mode decode
   logic cc_en, cc_mon, ratio_mode, ka;
   logic [1:0] cc_sens;
   logic [6:0] ratio_eff, pct_eff;
   logic [CW-1:0] ka_max;
   assign cc_en = (st_reg.cc_code != 7'h00);
   assign cc_sens = 2'(st_reg.cc_code / 7'h0A);
   assign cc_mon = st_reg.cc_code[0];
   assign ratio_mode = (st_reg.cc_code >= RATIO_LO) && (st_reg.cc_code <= RATIO_HI);
   assign ratio_eff = (st_reg.rr_int > RATIO_MAX) ? RATIO_MAX : st_reg.rr_int;
   assign pct_eff = (st_reg.rr_frac > PCT_FRAC_MAX) ? PCT_FRAC_MAX : st_reg.rr_frac;
   assign ka_max = CW'(14'(st_reg.rr_int) * 14'h0064 + 14'(pct_eff));
   assign ka = cc_en && !ratio_mode && st_reg.range_ka;

   // Offset code decode
   logic off_single, off_all, off_en;
   logic [4:0] mag;
   wcol_pfx_t pfx;
   assign off_single = (st_reg.off_code != 6'h00) && (st_reg.off_code < OFF_SPLIT);
   assign off_all = (st_reg.off_code > OFF_SPLIT) && (st_reg.off_code <= OFF_LAST);
   assign off_en = off_single || off_all;
   assign mag = off_all ? 5'(st_reg.off_code - OFF_SPLIT) : (off_single ? 5'(st_reg.off_code) : 5'h00);
   assign pfx = off_single ? WCOL_PFX_S : (off_all ? WCOL_PFX_A : WCOL_PFX_NONE);

   // Window around the unchanged base of the shown schedule
   logic [CW-1:0] cur_base, work, win, top, lo, hi, src, tgt, stp;
   logic [CW:0] cur_dlt, hi_raw, nd;
   logic [18:0] wprod;
   assign cur_base = st_reg.base[st_reg.sel];
   assign cur_dlt = st_reg.dlt[st_reg.sel];
   assign work = wk_all[st_reg.sel];
   assign wprod = 19'(ka_max) * 19'(mag);
   assign win = ka ? CW'(wprod / 19'h0_0064) : CW'(mag);
   assign top = ka ? ((ka_max > CUR_MAX) ? CUR_MAX : ka_max) : PCT_MAX;
   assign lo = (cur_base > win) ? CW'(cur_base - win) : '0;
   assign hi_raw = {1'b0, cur_base} + {1'b0, win};
   assign hi = (hi_raw > {1'b0, top}) ? top : hi_raw[CW-1:0];
   assign src = st_reg.pend ? st_reg.edit : work;
   assign stp = bt.up ? CW'(src + 14'h0001) : ((src == '0) ? '0 : CW'(src - 14'h0001));
   assign tgt = (stp > hi) ? hi : ((stp < lo) ? lo : stp);
   assign nd = {1'b0, (bt.enter ? st_reg.edit : tgt)} - {1'b0, cur_base};

   // APB decode
   logic setup, wr, mapped;
   logic [31:0] rd;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign mapped = (paddr <= A_EFF) && (paddr[1:0] == 2'b00);

   // Read data mux
   always_comb begin
      rd = '0;
      unique case (paddr)
         A_CTRL: begin
            rd[CTRL_PROG] = st_reg.prog;
            rd[CTRL_KA] = st_reg.range_ka;
            rd[CTRL_CC_LSB +: 7] = st_reg.cc_code;
            rd[CTRL_OFF_LSB +: 6] = st_reg.off_code;
         end
         A_RR: begin
            rd[RR_FRAC_LSB +: 7] = st_reg.rr_frac;
            rd[RR_INT_LSB +: 7] = st_reg.rr_int;
         end
         A_SEL: rd[SW-1:0] = st_reg.sel;
         A_BASE: rd[CW-1:0] = cur_base;
         A_STAT: begin
            rd[CW-1:0] = work;
            rd[ST_PFX_LSB +: 2] = pfx;
            rd[ST_FLASH] = st_reg.flash;
            rd[ST_ALT] = st_reg.shown;
            rd[ST_SINGLE] = off_single;
            rd[ST_ALL] = off_all;
            rd[ST_CCEN] = cc_en;
            rd[ST_SENS_LSB +: 2] = cc_sens;
            rd[ST_MON] = cc_mon;
            rd[ST_PEND] = st_reg.pend;
         end
         A_LIM: begin
            rd[CW-1:0] = lo;
            rd[LIM_HI_LSB +: CW] = hi;
         end
         A_EFF: begin
            rd[6:0] = ratio_eff;
            rd[EFF_PCT_LSB +: 7] = pct_eff;
            rd[EFF_KA_LSB +: CW] = ka_max;
         end
         default: rd = '0;
      endcase
   end

   // Next-state logic
   logic flash_now, tick;
   always_comb begin
      st_next = st_reg;
      // Read data is latched in the setup cycle, so no wait states
      if (setup) begin
         st_next.prdata = rd;
         st_next.pslverr = !mapped;
      end
      if (wr) begin
         unique case (paddr)
            A_CTRL: begin
               st_next.prog = pwdata[CTRL_PROG];
               st_next.range_ka = pwdata[CTRL_KA];
               st_next.cc_code = pwdata[CTRL_CC_LSB +: 7];
               st_next.off_code = pwdata[CTRL_OFF_LSB +: 6];
               st_next.pend = 1'b0;
            end
            A_RR: begin
               st_next.rr_frac = pwdata[RR_FRAC_LSB +: 7];
               st_next.rr_int = pwdata[RR_INT_LSB +: 7];
            end
            A_SEL: begin
               st_next.sel = pwdata[SW-1:0];
               st_next.pend = 1'b0;
            end
            A_BASE: begin
               // Base is locked outside program mode
               if (st_reg.prog) begin
                  st_next.base[st_reg.sel] = (pwdata[CW-1:0] > CUR_MAX) ? CUR_MAX : pwdata[CW-1:0];
               end
            end
            default: begin
            end
         endcase
      end
      if (!st_reg.prog && off_en) begin
         if ((bt.up ^ bt.down) && ka) begin
            st_next.edit = tgt;
            st_next.pend = 1'b1;
         end else if (((bt.up ^ bt.down) && !ka) || (bt.enter && ka && st_reg.pend)) begin
            st_next.pend = 1'b0;
            for (int i = 0; i < NSCHED; i++) begin
               if (off_all || (SW'(i) == st_reg.sel)) begin
                  st_next.dlt[i] = nd;
               end
            end
         end
      end
      if (st_reg.prog && off_en && bt.enter) begin
         for (int i = 0; i < NSCHED; i++) begin
            if (off_all || (SW'(i) == st_reg.sel)) begin
               st_next.base[i] = wk_all[i];
               st_next.dlt[i] = '0;
            end
         end
      end
      flash_now = st_reg.prog && off_en && (cur_dlt != '0);
      tick = (st_reg.tcnt == TW'(ALT_CYC - 1));
      if (flash_now) begin
         st_next.tcnt = tick ? '0 : TW'(st_reg.tcnt + 1'b1);
         st_next.alt = tick ? !st_reg.alt : st_reg.alt;
      end else begin
         st_next.tcnt = '0;
         st_next.alt = 1'b0;
      end
      // Display registers
      st_next.flash = flash_now;
      st_next.shown = flash_now && st_reg.alt;
      st_next.pfx = pfx;
      if (st_reg.prog) begin
         st_next.disp = (flash_now && st_reg.alt) ? work : cur_base;
      end else begin
         st_next.disp = src;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.prog <= RST_PROG;
         st_reg.off_code <= RST_OFF;
         st_reg.cc_code <= RST_CC;
         st_reg.base <= {NSCHED{RST_BASE}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pslverr = st_reg.pslverr;
   assign pready = 1'b1;
   assign disp_value = st_reg.disp;
   assign disp_prefix = st_reg.pfx;
   assign disp_flash = st_reg.flash;
   assign disp_offset_shown = st_reg.shown;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ratio;
      (st_reg.rr_int > RATIO_MAX) |-> (ratio_eff == 7'h7D);
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio not capped");

   property p_pct;
      ka || (pct_eff <= 7'h63);
   endproperty
   a_pct: assert property (p_pct) else $error("percent range out of steps");

   property p_cc;
      (st_reg.cc_code == 7'h1F) |-> (cc_en && cc_mon && cc_sens == 2'd3 && !ratio_mode);
   endproperty
   a_cc: assert property (p_cc) else $error("mode selector decode wrong");

   property p_dec;
      (st_reg.off_code == 6'h14) |-> (!off_en && mag == 5'h00);
   endproperty
   a_dec: assert property (p_dec) else $error("code twenty not disabled");

   property p_mag;
      (st_reg.off_code == 6'h15) |-> (off_all && mag == 5'h01);
   endproperty
   a_mag: assert property (p_mag) else $error("all-schedule magnitude wrong");

   property p_pfx;
      (off_single && $stable(st_reg.off_code)) |=> (disp_prefix == WCOL_PFX_S);
   endproperty
   a_pfx: assert property (p_pfx) else $error("single prefix missing");

   property p_lock;
      (!st_reg.prog && !$past(st_reg.prog) && !$past(bt.enter)) |-> $stable(st_reg.base);
   endproperty
   a_lock: assert property (p_lock) else $error("base moved in operate");

   property p_clamp;
      (!st_reg.prog && off_en && !ka && bt.up && !wr) |=> (work == $past(tgt) && work <= $past(hi));
   endproperty
   a_clamp: assert property (p_clamp) else $error("adjust not clamped");

   property p_kahold;
      (!st_reg.prog && ka && off_en && (bt.up ^ bt.down)) |=> ($stable(st_reg.dlt) && st_reg.pend);
   endproperty
   a_kahold: assert property (p_kahold) else $error("kA edit stored early");

   property p_all;
      (!st_reg.prog && off_all && !ka && bt.up && !wr) |=> (&dlt_eq);
   endproperty
   a_all: assert property (p_all) else $error("schedules shifted unequally");

   property p_copy;
      (st_reg.prog && off_single && bt.enter && !wr) |=> (cur_dlt == '0 && cur_base == $past(work));
   endproperty
   a_copy: assert property (p_copy) else $error("enter did not copy offset");

   property p_flash;
      disp_flash |-> ($past(st_reg.prog) && $past(cur_dlt) != '0);
   endproperty
   a_flash: assert property (p_flash) else $error("flash without offset");

   c_ka_commit: cover property (st_reg.pend && bt.enter && !st_reg.prog);
   c_all_adj: cover property (off_all && bt.down && !st_reg.prog);
   c_copy: cover property (st_reg.prog && off_en && bt.enter);
   c_alt: cover property (disp_offset_shown ##1 !disp_offset_shown);
endmodule

/* File: wcol_pkg.sv */
// Shared constants and carrier types of the weld current offset limiter
package wcol_pkg;
   // Current values: percent units or hundredths of kA
   localparam int CW = 14;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_RR = 8'h04;
   localparam logic [7:0] A_SEL = 8'h08;
   localparam logic [7:0] A_BASE = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_LIM = 8'h14;
   localparam logic [7:0] A_EFF = 8'h18;
   // Field positions
   localparam int CTRL_PROG = 0;
   localparam int CTRL_KA = 1;
   localparam int CTRL_CC_LSB = 8;
   localparam int CTRL_OFF_LSB = 16;
   localparam int RR_FRAC_LSB = 0;
   localparam int RR_INT_LSB = 8;
   localparam int ST_PFX_LSB = 14;
   localparam int ST_FLASH = 16;
   localparam int ST_ALT = 17;
   localparam int ST_SINGLE = 18;
   localparam int ST_ALL = 19;
   localparam int ST_CCEN = 20;
   localparam int ST_SENS_LSB = 21;
   localparam int ST_MON = 23;
   localparam int ST_PEND = 24;
   localparam int LIM_HI_LSB = 16;
   localparam int EFF_PCT_LSB = 8;
   localparam int EFF_KA_LSB = 16;
   // Limits and code boundaries
   localparam logic [6:0] RATIO_MAX = 7'h7D;
   localparam logic [6:0] RATIO_LO = 7'h0C;
   localparam logic [6:0] RATIO_HI = 7'h11;
   localparam logic [6:0] PCT_FRAC_MAX = 7'h63;
   localparam logic [CW-1:0] PCT_MAX = 14'h0063;
   localparam logic [CW-1:0] CUR_MAX = 14'h270F;
   localparam logic [5:0] OFF_SPLIT = 6'h14;
   localparam logic [5:0] OFF_LAST = 6'h27;
   // Values after reset
   localparam logic RST_PROG = 1'b0;
   localparam logic [5:0] RST_OFF = 6'h00;
   localparam logic [6:0] RST_CC = 7'h00;
   localparam logic [CW-1:0] RST_BASE = 14'h0000;
   // Program-mode display alternation
   localparam int ALT_TIME_MS = 500;
   localparam int CLK_KHZ = 100000;
   localparam int ALT_CYCLES = ALT_TIME_MS * CLK_KHZ;
   // Data display prefix digit
   typedef enum logic [1:0] {
      WCOL_PFX_NONE = 2'b00,
      WCOL_PFX_S = 2'b01,
      WCOL_PFX_A = 2'b10
   } wcol_pfx_t;
   // Front panel button strobes
   typedef struct packed {
      logic up;
      logic down;
      logic enter;
   } wcol_btn_t;
endpackage

/* File: wcol_btn_sync.sv */
// Three-stage button synchroniser with press pulse
`timescale 1ns/1ps
module wcol_btn_sync import wcol_pkg::*; #(
   parameter int N = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] pin_in,
   output logic [N-1:0] press
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] stable;
      logic [N-1:0] rise;
   } wcol_sync_st_t;
   wcol_sync_st_t st_reg, st_next;
   logic [N-1:0] agree;

   // A change counts only once stages two and three agree
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      agree = ~(st_reg.s2 ^ st_reg.s3);
      st_next.stable = (st_reg.stable & ~agree) | (st_reg.s3 & agree);
      st_next.rise = st_next.stable & ~st_reg.stable;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign press = st_reg.rise;
endmodule

/* File: wcol_panel_model.sv */
// Operator front panel model that works the three buttons
`timescale 1ns/1ps
module wcol_panel_model import wcol_pkg::*; #(
   parameter int HOLD = 6
) (
   input wire logic pclk,
   output wcol_btn_t btn
);
   // Released buttons sit low, as on the pulled-down pins
   initial begin
      btn = '0;
   end

   // One press: hold, then release long enough for the filter
   task automatic press(input int which, input int hold);
      @(posedge pclk);
      case (which)
         0: btn.up <= 1'b1;
         1: btn.down <= 1'b1;
         default: btn.enter <= 1'b1;
      endcase
      repeat (hold) @(posedge pclk);
      btn <= '0;
      repeat (hold + 2) @(posedge pclk); // Release span also filtered
   endtask
endmodule

/* File: tb_weld_current_offset_limiter.sv */
// Self-checking bench for the current offset limiter
`timescale 1ns/1ps
module tb_weld_current_offset_limiter import wcol_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic disp_flash, disp_offset_shown;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [CW-1:0] disp_value;
   logic [1:0] disp_prefix;
   logic e, hi_seen, lo_seen;
   wcol_btn_t btn;
   int n_errors, total_checks;
   logic [5:0] codes [6] = '{6'h00, 6'h05, 6'h13, 6'h14, 6'h15, 6'h27};
   logic [5:0] stat_exp [6] = '{6'h00, 6'h11, 6'h11, 6'h00, 6'h22, 6'h22};
   logic [31:0] lim_exp [6] = '{32'h0032_0032, 32'h0037_002D, 32'h0045_001F, 32'h0032_0032,
      32'h0033_0031, 32'h0045_001F};

   wcol_top #(.NSCHED(8), .ALT_CYC(8)) i_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_up_pin(btn.up),
      .btn_down_pin(btn.down), .btn_enter_pin(btn.enter), .disp_value(disp_value),
      .disp_prefix(disp_prefix), .disp_flash(disp_flash),
      .disp_offset_shown(disp_offset_shown));

   wcol_panel_model i_panel (.pclk(pclk), .btn(btn));

   // Free-running 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Verdict and end of run, also reached on a timeout
   task automatic conclude();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // APB cycle: setup, then access held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_errors++;
         conclude();
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(a, 1'b1, wd);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(a, 1'b0, 32'h0000_0000);
   endtask

   task automatic presses(input int which, input int count);
      repeat (count) i_panel.press(which, 6);
   endtask

   // Main sequence
   initial begin
      n_errors = 0;
      total_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTRL);
      check("ctrl_reset", d, 32'h0000_0000);
      rd(A_STAT);
      check("stat_reset", d, 32'h0000_0000);
      // Unmapped place answers with an error and zero data
      rd(8'h1C);
      check("unmapped_err", {31'b0, e}, 32'h0000_0001);
      check("unmapped_data", d, 32'h0000_0000);
      // Ratio capped at 125, range fraction 99, kA max 127.99
      wr(A_RR, 32'h0000_7F63);
      rd(A_EFF);
      check("eff_ratio", d, 32'h31FF_637D);
      // Bases: sched0 50 %, sched1 30 %, sched2 14.00 kA
      wr(A_CTRL, 32'h0000_0001);
      wr(A_BASE, 32'h0000_0032);
      wr(A_SEL, 32'h0000_0001);
      wr(A_BASE, 32'h0000_001E);
      wr(A_SEL, 32'h0000_0002);
      wr(A_BASE, 32'h0000_0578);
      wr(A_SEL, 32'h0000_0000);
      wr(A_CTRL, 32'h0000_0000);
      wr(A_BASE, 32'h0000_0063);
      rd(A_BASE);
      check("base_locked", d, 32'h0000_0032);
      // Every offset code class, its prefix and its window
      for (int i = 0; i < 6; i++) begin
         wr(A_CTRL, 32'(codes[i]) << CTRL_OFF_LSB);
         rd(A_STAT);
         check("offset_mode", 32'(d[19:14]), 32'(stat_exp[i]));
         rd(A_LIM);
         check("window", d, lim_exp[i]);
      end
      // kA mode: presses only stage an edit until enter
      wr(A_RR, 32'h0000_1400);
      wr(A_SEL, 32'h0000_0002);
      wr(A_CTRL, 32'h0005_0A02);
      rd(A_LIM);
      check("ka_window", d, 32'h05DC_0514);
      presses(0, 1);
      rd(A_STAT);
      check("ka_pending", {d[24:20], 13'b0, d[13:0]}, 32'h9800_0578);
      presses(2, 1);
      rd(A_STAT);
      check("ka_commit", {d[24], 17'b0, d[13:0]}, 32'h0000_0579);
      // All-schedule mode, clamp at the upper then lower edge
      wr(A_SEL, 32'h0000_0000);
      wr(A_CTRL, 32'h0016_0000);
      presses(0, 3);
      rd(A_STAT);
      check("all_up_clamp", 32'(d[13:0]), 32'h0000_0034);
      check("disp_value", 32'(disp_value), 32'h0000_0034);
      check("disp_prefix", 32'(disp_prefix), 32'h0000_0002);
      wr(A_SEL, 32'h0000_0001);
      rd(A_STAT);
      check("all_shift", 32'(d[13:0]), 32'h0000_0020);
      wr(A_SEL, 32'h0000_0000);
      presses(1, 5);
      rd(A_STAT);
      check("all_dn_clamp", 32'(d[13:0]), 32'h0000_0030);
      // Single mode touches the shown schedule only; one slow press
      wr(A_CTRL, 32'h0002_0000);
      i_panel.press(0, 12);
      rd(A_STAT);
      check("single_up", 32'(d[13:0]), 32'h0000_0031);
      wr(A_SEL, 32'h0000_0001);
      rd(A_STAT);
      check("single_other", 32'(d[13:0]), 32'h0000_001C);
      wr(A_SEL, 32'h0000_0000);
      // Program mode: flash, alternation, enter copies offset to base
      wr(A_CTRL, 32'h0002_0001);
      rd(A_STAT);
      check("flash_reg", 32'(d[16]), 32'h0000_0001);
      check("flash_pin", 32'(disp_flash), 32'h0000_0001);
      hi_seen = 1'b0;
      lo_seen = 1'b0;
      repeat (40) begin
         @(negedge pclk);
         if (disp_offset_shown === 1'b1) hi_seen = 1'b1;
         if (disp_offset_shown === 1'b0) lo_seen = 1'b1;
      end
      check("alternate", {30'b0, hi_seen, lo_seen}, 32'h0000_0003);
      presses(2, 1);
      rd(A_BASE);
      check("enter_copy", d, 32'h0000_0031);
      rd(A_STAT);
      check("flash_off", 32'(d[16]), 32'h0000_0000);
      wr(A_SEL, 32'h0000_0001);
      rd(A_BASE);
      check("base_kept", d, 32'h0000_001E);
      // Sensor and monitor decode of the current mode code
      wr(A_CTRL, 32'h0000_1F00);
      rd(A_STAT);
      check("cc_31", 32'(d[23:20]), 32'h0000_000F);
      wr(A_CTRL, 32'h0000_0000);
      rd(A_STAT);
      check("cc_off", 32'(d[23:20]), 32'h0000_0000);
      check("pready", 32'(pready), 32'h0000_0001);
      conclude();
   end
endmodule
